// File: core/bulk_eeprom_device.sv
// EEPROM device end: instruction receiver, bulk self-timed cycle, status out.
// Assumes link pins are asynchronous to i_sys_clk and a host on the far end.
//
// Overview of operation
// [R1] Host holds select low least deselect time
// [R2] Select fall after erase-all starts clearing
// [R3] Erased locations all read as ones
// [R4] Host deselects after write-all data word
// [R5] Select fall after write-all fills array
// [R6] Write-all needs no prior erase
// [R7] Bulk cycle runs without serial clock
// [R8] Host polls data out while selected
// [R9] Data out low busy, high ready
// [R10] Start 1, opcode 00, subcode selects bulk
// [R11] Bulk refused until write enable accepted
`timescale 1ns/10ps
`default_nettype none
module bulk_eeprom_device #(
  parameter int DEPTH = eeprom_bulk_pkg::MEM_DEPTH,
  parameter int PROG_CYCLES = eeprom_bulk_pkg::PROG_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  bulk_link_if.device link,
  input wire logic [eeprom_bulk_pkg::ADDR_W-1:0] i_peek_addr,
  output logic [eeprom_bulk_pkg::DATA_W-1:0] o_peek_data,
  output logic o_busy,
  output logic o_write_en
);
  import eeprom_bulk_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);
  localparam int PCW = $clog2(PROG_CYCLES + 1);
  localparam int CNT_W = $clog2(WR_ALL_BITS + 1);

  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_HOLD} rx_t;
  typedef enum logic [1:0] {ARM_NONE, ARM_ERASE, ARM_WRITE} arm_t;

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sclk_prev_q;
  logic cs_prev_q;
  rx_t rx_q;
  arm_t arm_q;
  logic [CNT_W-1:0] cnt_q;
  logic [WR_ALL_BITS-1:0] sr_q;
  logic [DATA_W-1:0] data_q;
  logic wen_q;
  logic busy_q;
  logic stat_q;
  logic [PCW-1:0] pcnt_q;
  logic [DATA_W-1:0] fill_q;
  logic do_val_q;
  logic do_oe_q;
  logic [DATA_W-1:0] mem [DEPTH];

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= {link.cs, link.sclk, link.serial_data_in};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[1];
      cs_prev_q <= sync_q[2];
    end
  end

  logic cs_s;
  logic data_in_s;
  logic sclk_rise;
  logic cs_fall;
  assign cs_s = sync_q[2];
  assign data_in_s = sync_q[0];
  assign sclk_rise = sync_q[1] & ~sclk_prev_q;
  assign cs_fall = cs_prev_q & ~cs_s;

  // Bit taken on a serial clock rise while selected and idle
  logic take;
  logic [WR_ALL_BITS-1:0] nxt_sr;
  logic [1:0] op_n;
  logic [1:0] sub_n;
  logic at_cmd;
  logic at_data;
  assign take = cs_s & sclk_rise & ~busy_q;
  assign nxt_sr = {sr_q[WR_ALL_BITS-2:0], data_in_s};
  assign op_n = nxt_sr[OP_LSB +: OP_W];
  assign sub_n = nxt_sr[SUB_LSB +: 2];
  assign at_cmd = take && rx_q == RX_SHIFT && cnt_q == CNT_W'(CMD_BITS - 1);
  assign at_data = take && rx_q == RX_SHIFT && cnt_q == CNT_W'(WR_ALL_BITS - 1);

  //////////////////////////////////////////////////////////////////////////
  // Instruction receiver; deselect aborts a partial frame
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_q <= RX_IDLE;
      cnt_q <= '0;
      sr_q <= '0;
    end
    else if (!cs_s)
    begin
      rx_q <= RX_IDLE;
      cnt_q <= '0;
    end
    else if (take)
    begin
      case (rx_q)
        RX_IDLE:
        begin
          if (data_in_s)
            rx_q <= RX_SHIFT; // [R10]
          cnt_q <= '0;
        end
        RX_SHIFT:
        begin
          sr_q <= nxt_sr;
          cnt_q <= cnt_q + CNT_W'(1);
          // Only write-all carries a data field
          if (at_cmd && !(op_n == OP_SPECIAL && sub_n == SUB_WR_ALL))
            rx_q <= RX_HOLD; // [R10]
          else if (at_data)
            rx_q <= RX_HOLD;
        end
        RX_HOLD: rx_q <= RX_HOLD;
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Armed bulk operation, waiting for the select fall
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      arm_q <= ARM_NONE;
      data_q <= '0;
    end
    else if (!cs_s)
      arm_q <= ARM_NONE;
    else if (at_cmd && op_n == OP_SPECIAL && sub_n == SUB_ER_ALL)
      arm_q <= ARM_ERASE; // [R10]
    else if (at_data)
    begin
      arm_q <= ARM_WRITE; // [R10]
      data_q <= nxt_sr[DATA_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write enable latch; disabled after reset
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      wen_q <= 1'b0; // [R11]
    else if (at_cmd && op_n == OP_SPECIAL && sub_n == SUB_WR_ENABLE)
      wen_q <= 1'b1;
    else if (at_cmd && op_n == OP_SPECIAL && sub_n == SUB_WR_DISABLE)
      wen_q <= 1'b0;
  end

  logic start;
  assign start = cs_fall & (arm_q != ARM_NONE) & wen_q & ~busy_q; // [R2] [R5] [R11]

  //////////////////////////////////////////////////////////////////////////
  // Self-timed cycle, paced by the system clock alone
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy_q <= 1'b0;
      pcnt_q <= '0;
      fill_q <= '0;
    end
    else if (start)
    begin
      busy_q <= 1'b1;
      pcnt_q <= '0;
      fill_q <= (arm_q == ARM_ERASE) ? ERASED_BYTE : data_q; // [R3]
    end
    else if (busy_q)
    begin
      pcnt_q <= pcnt_q + PCW'(1); // [R7]
      if (pcnt_q == PCW'(PROG_CYCLES - 1))
        busy_q <= 1'b0;
    end
  end

  // Array walk; each location overwritten outright, no erase needed
  always_ff @(posedge i_sys_clk)
  begin
    if (busy_q && pcnt_q < PCW'(DEPTH))
      mem[pcnt_q[IDX_W-1:0]] <= fill_q; // [R2] [R5] [R6]
  end

  // Side read port for inspection of the array
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_peek_data <= '0;
    else
      o_peek_data <= mem[i_peek_addr[IDX_W-1:0]];
  end

  //////////////////////////////////////////////////////////////////////////
  // Status shown from cycle start until a dummy one is shifted in
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      stat_q <= 1'b0;
    else if (start)
      stat_q <= 1'b1; // [R8]
    else if (take && data_in_s)
      stat_q <= 1'b0;
  end

  // Registered pin drive; lags the synchronised select by one cycle
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      do_oe_q <= 1'b0;
      do_val_q <= 1'b0;
    end
    else
    begin
      do_oe_q <= cs_s & stat_q; // [R8]
      do_val_q <= ~busy_q; // [R9]
    end
  end

  assign link.do_oe = do_oe_q;
  assign link.do_val = do_val_q;
  assign o_busy = busy_q;
  assign o_write_en = wen_q;
endmodule // bulk_eeprom_device
`default_nettype wire

// File: include/eeprom_bulk_pkg.sv
// Shared constants for the serial EEPROM bulk erase/write link.
// Assumes byte organisation and a 125 MHz system clock on both ends.
package eeprom_bulk_pkg;
  localparam int SYS_PERIOD_NS = 8;
  localparam int OP_W = 2;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  // Bits after the start bit: opcode plus address field
  localparam int CMD_BITS = OP_W + ADDR_W;
  localparam int WR_ALL_BITS = CMD_BITS + DATA_W;
  localparam int FRAME_W = 1 + WR_ALL_BITS;
  localparam int OP_LSB = ADDR_W;
  localparam int SUB_LSB = ADDR_W - 2;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] SUB_WR_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WR_ALL = 2'h1;
  localparam logic [1:0] SUB_ER_ALL = 2'h2;
  localparam logic [1:0] SUB_WR_ENABLE = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int MEM_DEPTH = 256;
  // Serial clock half period made by the host divider
  localparam int SCLK_HALF_NS = 250;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Least deselect time, rounded up
  localparam int CSMIN_NS = 250;
  localparam int CSMIN_CYC = (CSMIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Self-timed bulk cycle length
  localparam int PROG_NS = 4000;
  localparam int PROG_CYC = PROG_NS / SYS_PERIOD_NS;
  // Host wait after reselect; covers both ends' synchronisers and the pin register
  localparam int POLL_LAT_CYC = 8;
  typedef enum logic [1:0] {BULK_ENABLE, BULK_DISABLE, BULK_ERASE_ALL, BULK_WRITE_ALL} bulk_cmd_t;
endpackage

// File: include/bulk_link_if.sv
// Four-wire serial link between host and EEPROM device.
// Data out is undriven unless enabled; an undriven line reads high (pull-up).
`timescale 1ns/10ps
`default_nettype none
interface bulk_link_if;
  logic cs;
  logic sclk;
  logic serial_data_in;
  logic do_val;
  logic do_oe;
  logic do_line;
  // Resolved pin level, pulled up when nobody drives
  assign do_line = do_oe ? do_val : 1'b1;
  modport device (input cs, input sclk, input serial_data_in, output do_val, output do_oe);
  modport host (output cs, output sclk, output serial_data_in, input do_line);
endinterface
`default_nettype wire

// File: core/bulk_eeprom_host.sv
// Host end: frames one bulk-related instruction per request and polls status after erase-all or write-all.
// Assumes the device end on the link; serial clock made here by a divider.
`timescale 1ns/10ps
`default_nettype none
module bulk_eeprom_host #(
  parameter int HALF_CYC = eeprom_bulk_pkg::SCLK_HALF_CYC,
  parameter int DESEL_CYC = eeprom_bulk_pkg::CSMIN_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  bulk_link_if.host link,
  input wire logic i_req_valid,
  input wire eeprom_bulk_pkg::bulk_cmd_t i_req_cmd,
  input wire logic [eeprom_bulk_pkg::DATA_W-1:0] i_req_data,
  output logic o_req_ready,
  output logic o_done
);
  import eeprom_bulk_pkg::*;

  localparam int DW = $clog2(HALF_CYC + 1);
  localparam int SW = $clog2(DESEL_CYC + 1);
  localparam int BW = $clog2(FRAME_W + 1);
  localparam int PLW = $clog2(POLL_LAT_CYC + 1);

  typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_DESEL, H_POLL, H_DUMMY} host_t;

  host_t st_q;
  logic [DW-1:0] div_q;
  logic [SW-1:0] dcnt_q;
  logic [PLW-1:0] plat_q;
  logic [BW-1:0] bits_q;
  logic [BW-1:0] nbits_q;
  logic [FRAME_W-1:0] sr_q;
  logic bulk_q;
  logic polled_q;
  logic cs_q;
  logic sclk_q;
  logic done_q;
  logic do_meta_q;
  logic do_sync_q;

  //////////////////////////////////////////////////////////////////////////
  // Free-running half-period divider
  logic tick;
  assign tick = div_q == DW'(HALF_CYC - 1);
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      div_q <= '0;
    else
      div_q <= tick ? '0 : div_q + DW'(1);
  end

  // Data-out pin synchroniser
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      do_meta_q <= 1'b0;
      do_sync_q <= 1'b0;
    end
    else
    begin
      do_meta_q <= link.do_line;
      do_sync_q <= do_meta_q;
    end
  end

  // Subcode chosen by the request
  logic [1:0] sub;
  always_comb
  begin
    case (i_req_cmd)
      BULK_ENABLE: sub = SUB_WR_ENABLE;
      BULK_DISABLE: sub = SUB_WR_DISABLE;
      BULK_ERASE_ALL: sub = SUB_ER_ALL;
      default: sub = SUB_WR_ALL;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer: frame out, deselect, poll, dummy one, deselect
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= H_IDLE;
      cs_q <= 1'b0;
      sclk_q <= 1'b0;
      sr_q <= '0;
      bits_q <= '0;
      nbits_q <= '0;
      dcnt_q <= '0;
      plat_q <= '0;
      bulk_q <= 1'b0;
      polled_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        H_IDLE:
        begin
          if (i_req_valid && tick)
          begin
            // Start bit, special opcode, subcode, padding, data
            sr_q <= {1'b1, OP_SPECIAL, sub, (ADDR_W - 2)'(0), i_req_data}; // [R10]
            nbits_q <= (i_req_cmd == BULK_WRITE_ALL) ? BW'(FRAME_W) : BW'(1 + CMD_BITS);
            bits_q <= '0;
            bulk_q <= i_req_cmd == BULK_ERASE_ALL || i_req_cmd == BULK_WRITE_ALL;
            polled_q <= 1'b0;
            cs_q <= 1'b1;
            st_q <= H_SHIFT;
          end
        end
        H_SHIFT:
        begin
          if (tick && !sclk_q)
            sclk_q <= 1'b1;
          else if (tick)
          begin
            sclk_q <= 1'b0;
            sr_q <= {sr_q[FRAME_W-2:0], 1'b0};
            bits_q <= bits_q + BW'(1);
            if (bits_q == nbits_q - BW'(1))
            begin
              cs_q <= 1'b0; // [R1] [R4]
              dcnt_q <= '0;
              st_q <= H_DESEL;
            end
          end
        end
        H_DESEL:
        begin
          dcnt_q <= dcnt_q + SW'(1);
          // Clock stays low while the device works alone
          if (dcnt_q >= SW'(DESEL_CYC - 1) && tick) // [R1] [R4] [R7]
          begin
            if (bulk_q && !polled_q)
            begin
              cs_q <= 1'b1; // [R8]
              plat_q <= '0;
              st_q <= H_POLL;
            end
            else
            begin
              done_q <= 1'b1;
              st_q <= H_IDLE;
            end
          end
        end
        H_POLL:
        begin
          // Pulled-up line reads ready until the device drives it; wait that out
          if (plat_q != PLW'(POLL_LAT_CYC))
            plat_q <= plat_q + PLW'(1);
          else if (tick && do_sync_q)
          begin
            sr_q <= {1'b1, (FRAME_W - 1)'(0)}; // [R8]
            st_q <= H_DUMMY;
          end
        end
        H_DUMMY:
        begin
          if (tick && !sclk_q)
            sclk_q <= 1'b1;
          else if (tick)
          begin
            sclk_q <= 1'b0;
            cs_q <= 1'b0;
            polled_q <= 1'b1;
            dcnt_q <= '0;
            st_q <= H_DESEL;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.cs = cs_q;
  assign link.sclk = sclk_q;
  assign link.serial_data_in = sr_q[FRAME_W-1];
  assign o_req_ready = st_q == H_IDLE && tick;
  assign o_done = done_q;
endmodule // bulk_eeprom_host
`default_nettype wire

// File: test/bulk_link_chk.sv
// Checker: timing relations on the wires of the bulk link.
// Assumes a host built with HALF_CYC 4; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module bulk_link_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic cs,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic do_val,
  input wire logic do_oe
);
  import eeprom_bulk_pkg::*;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Helper: sampled cycles with select low, saturating at the least gap
  int low_cnt_q;
  // Helper: first serial clock high of a selection already seen
  logic rise_seen_q;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      low_cnt_q <= CSMIN_CYC;
    else if (cs)
      low_cnt_q <= 0;
    else if (low_cnt_q < CSMIN_CYC)
      low_cnt_q <= low_cnt_q + 1;
  end
  // Reselect for polling carries no frame, so the start bit is judged at the clock
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      rise_seen_q <= 1'b0;
    else if (!cs)
      rise_seen_q <= 1'b0;
    else if (sclk)
      rise_seen_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Steps of a frame: serial clock pulse, deselect gap, quiet data-out
  sequence s_sclk_pulse;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_quiet;
    (!cs) [*5];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_deselect_min;
    $rose(cs) |-> low_cnt_q >= CSMIN_CYC;
  endproperty
  property p_clock_idle;
    !cs |-> !sclk;
  endproperty
  property p_sclk_half;
    $rose(sclk) |-> s_sclk_pulse;
  endproperty
  property p_di_stable;
    sclk |-> $stable(serial_data_in);
  endproperty
  property p_start_bit;
    cs && sclk && !rise_seen_q |-> serial_data_in;
  endproperty
  property p_busy_first;
    $rose(do_oe) |-> !do_val;
  endproperty
  property p_ready_holds;
    do_oe && do_val |=> do_val || !do_oe;
  endproperty
  property p_release;
    s_quiet |-> !do_oe;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_deselect_min: assert property (p_deselect_min)
    else $error("select gap too short");
  a_clock_idle: assert property (p_clock_idle)
    else $error("serial clock moves while deselected");
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock high phase wrong");
  a_di_stable: assert property (p_di_stable)
    else $error("data in moves while clock high");
  a_start_bit: assert property (p_start_bit)
    else $error("frame lacks start bit");
  a_busy_first: assert property (p_busy_first)
    else $error("status not busy when first driven");
  a_ready_holds: assert property (p_ready_holds)
    else $error("ready status fell back to busy");
  a_release: assert property (p_release)
    else $error("data out driven while deselected");
endmodule // bulk_link_chk
`default_nettype wire

// File: test/serial_eeprom_bulk_erase_write_tb_top.sv
// Testbench: host and device ends joined by one link, checked on the peek port.
// Assumes short divider and program counts so the run stays brief.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_bulk_erase_write_tb_top;
  import eeprom_bulk_pkg::*;
  localparam int PROG = 300;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic req_valid = 1'b0;
  bulk_cmd_t req_cmd = BULK_ENABLE;
  logic [DATA_W-1:0] req_data = 8'h00;
  logic [ADDR_W-1:0] peek_addr = 9'h000;
  logic [DATA_W-1:0] peek_data;
  logic busy, write_en, req_ready, done;
  int bad_count = 0;
  int checked = 0;
  int busy_len = 0;
  int busy_total = 0;
  bulk_link_if link_if ();
  ////////////////////////////////////////////////////////////////////////////
  bulk_eeprom_device #(.PROG_CYCLES(PROG)) bulk_eeprom_device_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link_if.device),
    .i_peek_addr(peek_addr), .o_peek_data(peek_data), .o_busy(busy),
    .o_write_en(write_en));
  bulk_eeprom_host #(.HALF_CYC(4), .DESEL_CYC(CSMIN_CYC)) bulk_eeprom_host_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link_if.host),
    .i_req_valid(req_valid), .i_req_cmd(req_cmd), .i_req_data(req_data),
    .o_req_ready(req_ready), .o_done(done));
  bulk_link_chk bulk_link_chk_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .cs(link_if.cs), .sclk(link_if.sclk),
    .serial_data_in(link_if.serial_data_in), .do_val(link_if.do_val),
    .do_oe(link_if.do_oe));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, and busy cycles counted per operation
  initial
  begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk)
  begin
    if (busy === 1'b1)
      busy_total <= busy_total + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    $display("[ERR] %0t wait limit used up", $time);
    results();
  endtask
  // One request, held until taken, then wait for done
  task automatic send(input bulk_cmd_t cmd, input logic [7:0] data);
    int n;
    int mark;
    mark = busy_total;
    n = 0;
    @(posedge i_sys_clk);
    req_cmd <= cmd;
    req_data <= data;
    req_valid <= 1'b1;
    do
    begin
      @(negedge i_sys_clk);
      n++;
      if (n > 1000) give_up();
    end while (req_ready !== 1'b1);
    @(posedge i_sys_clk);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge i_sys_clk);
      n++;
      if (n > 20000) give_up();
    end while (done !== 1'b1);
    // Busy cycles that fell inside this request
    busy_len = busy_total - mark;
  endtask
  // Every location read back; data comes one cycle after the address
  task automatic peek_all(input logic [7:0] exp);
    for (int a = 0; a < MEM_DEPTH; a++)
    begin
      @(posedge i_sys_clk);
      peek_addr <= 9'(a);
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      chk(16'(peek_data), 16'(exp));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_refused();
    chk(16'(write_en), 16'h0000);
    send(BULK_WRITE_ALL, 8'h5A);
    chk(16'(busy_len), 16'h0000);
  endtask
  task automatic t_erase();
    send(BULK_ENABLE, 8'h00);
    chk(16'(write_en), 16'h0001);
    send(BULK_ERASE_ALL, 8'h00);
    chk(16'(busy_len), 16'(PROG));
    peek_all(ERASED_BYTE);
  endtask
  task automatic t_write();
    send(BULK_WRITE_ALL, 8'hA5);
    chk(16'(busy_len), 16'(PROG));
    peek_all(8'hA5);
    send(BULK_WRITE_ALL, 8'h3C);
    peek_all(8'h3C);
  endtask
  task automatic t_disable();
    send(BULK_DISABLE, 8'h00);
    chk(16'(write_en), 16'h0000);
    send(BULK_ERASE_ALL, 8'h00);
    chk(16'(busy_len), 16'h0000);
    peek_all(8'h3C);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset held for eight cycles, then the scenarios in order
  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    t_refused();
    t_erase();
    t_write();
    t_disable();
    results();
  end
endmodule // serial_eeprom_bulk_erase_write_tb_top
`default_nettype wire
